// >>> rtl/synth_divider_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - A latched word with select 00 rewrites the feedback divide word.
// - Whole divide value is nine bits, host keeps it in 31..511.
// - Twelve-bit step numerator feeds the fractional interpolator.
// - Quick settle set forces maximum pump current, else programmed.
// - Monitor in switch mode pulls low while quick settle is set.
// - A latched word with select 01 rewrites the reference word.
// - Load control high stores resync delay, leaves denominator alone.
// - Monitor selection comes from bits 22 down to 20.
// - Normal precision locks after 24 clean phase-detector cycles.
// - Lock holds until new channel or error above 30 ns.
// - Serial bits shift in MSB first on rising serial clock.
// - Latch strobe rise copies shift word to one of four holders.
// - New denominator applies only after next feedback word write.
// - High precision locks after 40 clean phase-detector cycles.
module synth_divider_regs
   import synth_pkg::*;
#(
   parameter logic [5:0] LOCK_CNT_NORMAL = LOCK_CYCLES_NORMAL,
   parameter logic [5:0] LOCK_CNT_PRECISE = LOCK_CYCLES_PRECISE
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic latch_load_strobe,
   input wire logic pfd_tick,
   input wire logic pfd_err_below_min,
   input wire logic pfd_err_above_max,
   output logic [INT_W-1:0] whole_divide_value,
   output logic [F12_W-1:0] step_numerator,
   output logic [F12_W-1:0] step_denominator,
   output logic [F12_W-1:0] resync_delay,
   output logic quick_settle_bit,
   output logic [MON_W-1:0] monitor_select,
   output logic lock_precision_select,
   output logic [CP_W-1:0] cp_current,
   output logic [WORD_W-1:0] control_word,
   output logic [WORD_W-1:0] noise_word,
   output logic new_channel,
   output logic lock_detect,
   output logic monitor_output_o,
   output logic monitor_output_oe_n
);
   if (LOCK_CNT_PRECISE < LOCK_CNT_NORMAL) begin : g_chk
      $error("precise lock count below normal count");
   end

   // Twelve-bit field taken from a serial word
   function automatic logic [F12_W-1:0] field12(
      input logic [WORD_W-1:0] w,
      input int lsb
   );
      return w[lsb +: F12_W];
   endfunction

   typedef struct packed {
      logic [WORD_W-1:0] fb_word;
      logic [WORD_W-1:0] ref_word;
      logic [WORD_W-1:0] ctrl_word;
      logic [WORD_W-1:0] noise_word;
      logic [F12_W-1:0] den_pending;
      logic [F12_W-1:0] den_active;
      logic [F12_W-1:0] resync;
      logic [CP_W-1:0] cp;
      logic new_chan;
      logic mon_level;
      logic mon_oe_n;
   } regs_s;

   regs_s regs_r;
   regs_s regs_nxt;
   serial_word_if link ();
   logic [SEL_W-1:0] sel;
   logic fb_wr;
   logic ref_wr;
   logic [MON_W-1:0] mon_sel;
   logic qs_nxt;

   serial_capture u_capture (
      .clk (clk),
      .rst_n (rst_n),
      .serial_clk (serial_clk),
      .serial_data (serial_data),
      .latch_load_strobe (latch_load_strobe),
      .out (link.src)
   );

   // Lock restarts on every new channel
   lock_counter #(
      .CNT_NORMAL (LOCK_CNT_NORMAL),
      .CNT_PRECISE (LOCK_CNT_PRECISE)
   ) u_lock (
      .clk (clk),
      .rst_n (rst_n),
      .pfd_tick (pfd_tick),
      .err_below_min (pfd_err_below_min),
      .err_above_max (pfd_err_above_max),
      .precise (lock_precision_select),
      .restart (regs_r.new_chan),
      .lock_detect (lock_detect)
   );

   // Select decode of the latched word
   assign sel = link.word[SEL_LSB +: SEL_W];
   assign fb_wr = link.load && sel == SEL_FEEDBACK;
   assign ref_wr = link.load && sel == SEL_REFERENCE;

   // Holding registers and derived controls
   always_comb begin
      regs_nxt = regs_r;
      regs_nxt.new_chan = 1'b0;
      unique case (sel)
         SEL_FEEDBACK: begin
            if (link.load) begin
               regs_nxt.fb_word = link.word;
               regs_nxt.new_chan = 1'b1;
               regs_nxt.den_active = regs_r.den_pending;
            end
         end
         SEL_REFERENCE: begin
            if (link.load) begin
               regs_nxt.ref_word = link.word;
               if (link.word[LOAD_BIT]) begin
                  regs_nxt.resync = field12(link.word, DEN_LSB);
               end else begin
                  regs_nxt.den_pending = field12(link.word, DEN_LSB);
               end
            end
         end
         SEL_CONTROL: begin
            if (link.load) begin
               regs_nxt.ctrl_word = link.word;
            end
         end
         SEL_NOISE: begin
            if (link.load) begin
               regs_nxt.noise_word = link.word;
            end
         end
      endcase

      qs_nxt = regs_nxt.fb_word[QS_BIT];
      if (qs_nxt) begin
         regs_nxt.cp = CP_MAX;
      end else begin
         regs_nxt.cp = regs_nxt.ctrl_word[CP_LSB +: CP_W];
      end

      mon_sel = regs_nxt.ref_word[MON_LSB +: MON_W];
      unique case (mon_sel)
         MON_QS_SWITCH: begin
            regs_nxt.mon_level = 1'b0;
            regs_nxt.mon_oe_n = ~qs_nxt;
         end
         MON_LOCK_DETECT: begin
            regs_nxt.mon_level = lock_detect;
            regs_nxt.mon_oe_n = 1'b0;
         end
         default: begin
            // Unhandled selections leave the pin floating
            regs_nxt.mon_level = 1'b0;
            regs_nxt.mon_oe_n = 1'b1;
         end
      endcase
   end

   // Pin stays released in reset so the board pull-up wins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regs_r <= '0;
         regs_r.mon_oe_n <= 1'b1;
      end else begin
         regs_r <= regs_nxt;
      end
   end

   // Field outputs straight from holding flops
   // nine-bit whole divide value
   assign whole_divide_value = regs_r.fb_word[INT_LSB +: INT_W];
   assign step_numerator = field12(regs_r.fb_word, NUM_LSB);
   assign quick_settle_bit = regs_r.fb_word[QS_BIT];
   assign step_denominator = regs_r.den_active;
   assign resync_delay = regs_r.resync;
   assign monitor_select = regs_r.ref_word[MON_LSB +: MON_W];
   assign lock_precision_select = regs_r.ctrl_word[LDP_BIT];
   assign cp_current = regs_r.cp;
   assign control_word = regs_r.ctrl_word;
   assign noise_word = regs_r.noise_word;
   assign new_channel = regs_r.new_chan;
   assign monitor_output_o = regs_r.mon_level;
   assign monitor_output_oe_n = regs_r.mon_oe_n;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   fb_update_a: assert property (
      fb_wr |=> regs_r.fb_word == $past(link.word)
         && new_channel)
      else $error("feedback word not taken from latched word");
   num_field_a: assert property (
      fb_wr |=> step_numerator == $past(link.word[NUM_LSB +: F12_W])
         && whole_divide_value == $past(link.word[INT_LSB +: INT_W]))
      else $error("numerator or whole value field misplaced");
   ref_update_a: assert property (
      ref_wr |=> regs_r.ref_word == $past(link.word)
         && monitor_select == $past(link.word[MON_LSB +: MON_W]))
      else $error("reference word not taken from latched word");
   resync_load_a: assert property (
      ref_wr && link.word[LOAD_BIT]
      |=> $stable(regs_r.den_pending)
         && resync_delay == $past(link.word[DEN_LSB +: F12_W]))
      else $error("load control did not divert field to resync delay");
   den_buffer_a: assert property (
      fb_wr |=> step_denominator == $past(regs_r.den_pending))
      else $error("denominator not applied on feedback write");
   den_hold_a: assert property (
      !fb_wr |=> $stable(step_denominator))
      else $error("denominator changed without feedback write");
   hold_word_a: assert property (
      link.load && sel != SEL_FEEDBACK |=> $stable(regs_r.fb_word))
      else $error("feedback word disturbed by another select");
   qs_current_a: assert property (
      fb_wr && link.word[QS_BIT] |=> cp_current == CP_MAX
         ##1 (cp_current == CP_MAX || !quick_settle_bit))
      else $error("quick settle did not force maximum current");
   qs_switch_a: assert property (
      monitor_select == MON_QS_SWITCH
      |-> monitor_output_oe_n == !quick_settle_bit
         && !monitor_output_o)
      else $error("switch mode pin wrong for quick settle");
   ldp_route_a: assert property (
      link.load && sel == SEL_CONTROL
      |=> lock_precision_select == $past(link.word[LDP_BIT]))
      else $error("precision select not taken from control word");

   // Other holders stay put while one is written
   ref_hold_a: assert property (
      link.load && sel != SEL_REFERENCE |=> $stable(regs_r.ref_word))
      else $error("reference word disturbed by another select");
   ctrl_hold_a: assert property (
      link.load && sel != SEL_CONTROL |=> $stable(control_word))
      else $error("control word disturbed by another select");
   noise_hold_a: assert property (
      link.load && sel != SEL_NOISE |=> $stable(noise_word))
      else $error("noise word disturbed by another select");
   // Writes to the upper two holders
   ctrl_update_a: assert property (
      link.load && sel == SEL_CONTROL
      |=> control_word == $past(link.word))
      else $error("control word not taken from latched word");
   noise_update_a: assert property (
      link.load && sel == SEL_NOISE
      |=> noise_word == $past(link.word))
      else $error("noise word not taken from latched word");
   // Denominator path of a reference write
   den_pending_a: assert property (
      ref_wr && !link.word[LOAD_BIT]
      |=> regs_r.den_pending == $past(link.word[DEN_LSB +: F12_W])
         && $stable(resync_delay))
      else $error("denominator write went astray");
   // Quick settle level and programmed current when it is clear
   qs_route_a: assert property (
      fb_wr |=> quick_settle_bit == $past(link.word[QS_BIT]))
      else $error("quick settle bit not taken from feedback word");
   cp_prog_a: assert property (
      !quick_settle_bit |-> cp_current == control_word[CP_LSB +: CP_W])
      else $error("pump current not taken from control word");
   // Monitor pin in lock detect and in unused selections
   mon_lock_a: assert property (
      monitor_select == MON_LOCK_DETECT
      |-> !monitor_output_oe_n && monitor_output_o == $past(lock_detect))
      else $error("monitor pin does not show lock detect");
   mon_float_a: assert property (
      monitor_select != MON_LOCK_DETECT && monitor_select != MON_QS_SWITCH
      |-> monitor_output_oe_n)
      else $error("monitor pin driven in an unused selection");
   // New channel pulse is one cycle and always drops lock
   chan_pulse_a: assert property (
      new_channel |=> !new_channel)
      else $error("new channel pulse longer than one cycle");
   chan_drop_a: assert property (
      new_channel |=> !lock_detect)
      else $error("lock kept across a new channel");

   resync_cov: cover property (ref_wr && link.word[LOAD_BIT]);
   qs_pin_cov: cover property (
      monitor_select == MON_QS_SWITCH && !monitor_output_oe_n);
   retune_cov: cover property (lock_detect ##1 new_channel);
endmodule

// >>> rtl/synth_pkg.sv
package synth_pkg;
   // Serial word layout
   localparam int WORD_W = 24;
   localparam int SEL_LSB = 0;
   localparam int SEL_W = 2;
   localparam logic [1:0] SEL_FEEDBACK = 2'h0;
   localparam logic [1:0] SEL_REFERENCE = 2'h1;
   localparam logic [1:0] SEL_CONTROL = 2'h2;
   localparam logic [1:0] SEL_NOISE = 2'h3;
   // Feedback divide word fields
   localparam int F12_W = 12;
   localparam int NUM_LSB = 2;
   localparam int INT_LSB = 14;
   localparam int INT_W = 9;
   localparam int QS_BIT = 23;
   // Reference divide word fields
   localparam int DEN_LSB = 2;
   localparam int MON_LSB = 20;
   localparam int MON_W = 3;
   localparam int LOAD_BIT = 23;
   // Control word fields
   localparam int LDP_BIT = 5;
   localparam int CP_LSB = 7;
   localparam int CP_W = 4;
   localparam logic [3:0] CP_MAX = 4'hF;
   // Monitor output selections
   localparam logic [2:0] MON_LOCK_DETECT = 3'h6;
   localparam logic [2:0] MON_QS_SWITCH = 3'h7;
   // Lock detector counts, in phase-detector cycles
   localparam int LOCK_W = 6;
   localparam logic [5:0] LOCK_CYCLES_NORMAL = 6'h18;
   localparam logic [5:0] LOCK_CYCLES_PRECISE = 6'h28;
   // Whole divide range the host must keep to
   localparam logic [8:0] INT_MIN = 9'h01F;
   localparam logic [8:0] INT_MAX = 9'h1FF;
endpackage

// >>> rtl/serial_word_if.sv
`timescale 1ns/100ps
interface serial_word_if;
   import synth_pkg::*;
   logic [WORD_W-1:0] word;
   logic load;
   modport src (output word, output load);
   modport dst (input word, input load);
endinterface

// >>> rtl/serial_capture.sv
`timescale 1ns/100ps
module serial_capture
   import synth_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic latch_load_strobe,
   serial_word_if.src out
);
   typedef struct packed {
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_d;
      logic data_s1;
      logic data_s2;
      logic le_s1;
      logic le_s2;
      logic le_d;
      logic [WORD_W-1:0] shift;
      logic [WORD_W-1:0] word;
      logic load;
   } cap_s;

   cap_s cap_r;
   cap_s cap_nxt;
   logic sclk_rise;
   logic le_rise;

   // Edges seen only on second stages, never the first
   assign sclk_rise = cap_r.sclk_s2 & ~cap_r.sclk_d;
   assign le_rise = cap_r.le_s2 & ~cap_r.le_d;

   // Synchronise pins, shift and latch
   always_comb begin
      cap_nxt = cap_r;
      cap_nxt.sclk_s1 = serial_clk;
      cap_nxt.sclk_s2 = cap_r.sclk_s1;
      cap_nxt.sclk_d = cap_r.sclk_s2;
      cap_nxt.data_s1 = serial_data;
      cap_nxt.data_s2 = cap_r.data_s1;
      cap_nxt.le_s1 = latch_load_strobe;
      cap_nxt.le_s2 = cap_r.le_s1;
      cap_nxt.le_d = cap_r.le_s2;
      if (sclk_rise) begin
         cap_nxt.shift = {cap_r.shift[WORD_W-2:0], cap_r.data_s2};
      end
      cap_nxt.load = le_rise;
      if (le_rise) begin
         cap_nxt.word = cap_r.shift;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cap_r <= '0;
      end else begin
         cap_r <= cap_nxt;
      end
   end

   assign out.word = cap_r.word;
   assign out.load = cap_r.load;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   shift_in_a: assert property (
      sclk_rise |=> cap_r.shift[0] == $past(cap_r.data_s2))
      else $error("shift bit not taken on serial clock rise");
   latch_copy_a: assert property (
      le_rise |=> out.load && out.word == $past(cap_r.shift))
      else $error("latched word differs from shift register");
   word_cov: cover property (le_rise);
endmodule

// >>> rtl/lock_counter.sv
`timescale 1ns/100ps
module lock_counter
   import synth_pkg::*;
#(
   parameter logic [5:0] CNT_NORMAL = LOCK_CYCLES_NORMAL,
   parameter logic [5:0] CNT_PRECISE = LOCK_CYCLES_PRECISE
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pfd_tick,
   input wire logic err_below_min,
   input wire logic err_above_max,
   input wire logic precise,
   input wire logic restart,
   output logic lock_detect
);
   if (CNT_NORMAL == 6'h00 || CNT_PRECISE == 6'h00) begin : g_chk
      $error("lock counts must be nonzero");
   end

   typedef struct packed {
      logic [LOCK_W-1:0] cnt;
      logic locked;
   } lock_s;

   lock_s lk_r;
   lock_s lk_nxt;
   logic [LOCK_W-1:0] target;

   assign target = precise ? CNT_PRECISE : CNT_NORMAL;

   // Count clean cycles; a middling error only restarts the count
   always_comb begin
      lk_nxt = lk_r;
      // new channel or large error drops lock
      if (restart || (pfd_tick && err_above_max)) begin
         lk_nxt.cnt = '0;
         lk_nxt.locked = 1'b0;
      end else if (pfd_tick) begin
         if (err_below_min) begin
            if (lk_r.cnt != '1) begin
               lk_nxt.cnt = lk_r.cnt + 1'b1;
            end
            if (lk_r.cnt + 1'b1 >= target) begin
               lk_nxt.locked = 1'b1;
            end
         end else begin
            lk_nxt.cnt = '0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lk_r <= '0;
      end else begin
         lk_r <= lk_nxt;
      end
   end

   assign lock_detect = lk_r.locked;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Last clean tick of a normal run
   lock_normal_a: assert property (
      pfd_tick && err_below_min && !err_above_max && !restart
         && !precise && lk_r.cnt == CNT_NORMAL - 6'h01
      |=> lock_detect)
      else $error("lock not set after normal run");
   lock_precise_a: assert property (
      $rose(lock_detect) && $past(precise)
      |-> $past(lk_r.cnt) >= CNT_PRECISE - 6'h01)
      else $error("precise lock set too early");
   lock_drop_a: assert property (
      restart || (pfd_tick && err_above_max) |=> !lock_detect)
      else $error("lock kept after channel change or large error");
   lock_cov: cover property ($rose(lock_detect));
   drop_cov: cover property ($fell(lock_detect));
endmodule

// >>> bench/host_link_model.sv
`timescale 1ns/100ps
module host_link_model
   import synth_pkg::*;
(
   input wire logic clk,
   output logic serial_clk,
   output logic serial_data,
   output logic latch_load_strobe
);
   // Clock and strobe idle low and still between frames; data starts high
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b1;
      latch_load_strobe = 1'b0;
   end

   // One word out, then a latch pulse; 125 ns serial period
   task automatic send_word(input logic [WORD_W-1:0] w);
      @(negedge clk);
      for (int i = WORD_W - 1; i >= 0; i--) begin
         serial_data = w[i];
         #62.5 serial_clk = 1'b1;
         // Hold time over, so the line no longer shows the bit
         #30 serial_data = ~w[i];
         #32.5 serial_clk = 1'b0;
      end
      #40;
      @(negedge clk);
      latch_load_strobe = 1'b1;
      #40 latch_load_strobe = 1'b0;
   endtask
endmodule

// >>> bench/synth_divider_regs_lock_detect_tb.sv
`timescale 1ns/100ps
module synth_divider_regs_lock_detect_tb
   import synth_pkg::*;
;
   logic clk, rst_n, serial_clk, serial_data, latch_load_strobe;
   logic pfd_tick, pfd_err_below_min, pfd_err_above_max;
   logic [INT_W-1:0] whole_divide_value;
   logic [F12_W-1:0] step_numerator, step_denominator, resync_delay;
   logic quick_settle_bit, lock_precision_select, new_channel;
   logic [MON_W-1:0] monitor_select;
   logic [CP_W-1:0] cp_current;
   logic [WORD_W-1:0] control_word, noise_word;
   logic lock_detect, monitor_output_o, monitor_output_oe_n;
   logic [103:0] exp_q[$];
   logic [15:0] rnd;
   logic [INT_W-1:0] ex_int;
   logic [F12_W-1:0] ex_num, ex_den, ex_pend, ex_res;
   logic ex_qs;
   logic [MON_W-1:0] ex_mon;
   logic [CP_W-1:0] ex_cp;
   logic [WORD_W-1:0] ex_ctrl, ex_noise;
   int failures, tests_run;
   wire logic [103:0] obs;

   // Released pin level is masked, it carries no meaning
   assign obs = {new_channel, whole_divide_value, step_numerator,
      step_denominator, resync_delay, quick_settle_bit, monitor_select,
      cp_current, control_word, noise_word, monitor_output_oe_n,
      monitor_output_o & ~monitor_output_oe_n};

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   synth_divider_regs uut (
      .clk(clk),
      .rst_n(rst_n),
      .serial_clk(serial_clk),
      .serial_data(serial_data),
      .latch_load_strobe(latch_load_strobe),
      .pfd_tick(pfd_tick),
      .pfd_err_below_min(pfd_err_below_min),
      .pfd_err_above_max(pfd_err_above_max),
      .whole_divide_value(whole_divide_value),
      .step_numerator(step_numerator),
      .step_denominator(step_denominator),
      .resync_delay(resync_delay),
      .quick_settle_bit(quick_settle_bit),
      .monitor_select(monitor_select),
      .lock_precision_select(lock_precision_select),
      .cp_current(cp_current),
      .control_word(control_word),
      .noise_word(noise_word),
      .new_channel(new_channel),
      .lock_detect(lock_detect),
      .monitor_output_o(monitor_output_o),
      .monitor_output_oe_n(monitor_output_oe_n)
   );

   host_link_model host (
      .clk(clk),
      .serial_clk(serial_clk),
      .serial_data(serial_data),
      .latch_load_strobe(latch_load_strobe)
   );

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic step_rnd();
      rnd = lfsr_next(rnd);
   endtask

   task automatic check(input logic [103:0] seen, input logic [103:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("tests_run=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Reference model of the holding words, then the word goes out
   task automatic wr(input logic [WORD_W-1:0] w);
      logic oe_n;
      case (w[SEL_LSB +: SEL_W])
         SEL_FEEDBACK: begin
            ex_int = w[INT_LSB +: INT_W];
            ex_num = w[NUM_LSB +: F12_W];
            ex_qs = w[QS_BIT];
            ex_den = ex_pend;
         end
         // reference update, resync instead of denominator when load bit set
         SEL_REFERENCE: begin
            if (w[LOAD_BIT])
               ex_res = w[DEN_LSB +: F12_W];
            else
               ex_pend = w[DEN_LSB +: F12_W];
            ex_mon = w[MON_LSB +: MON_W];
         end
         SEL_CONTROL: ex_ctrl = w;
         default: ex_noise = w;
      endcase
      ex_cp = ex_qs ? CP_MAX : ex_ctrl[CP_LSB +: CP_W];
      // switch pulls low only while quick settle set
      oe_n = (ex_mon == MON_QS_SWITCH) ? ~ex_qs : (ex_mon != MON_LOCK_DETECT);
      exp_q.push_back({w[1:0] == SEL_FEEDBACK, ex_int, ex_num, ex_den, ex_res,
         ex_qs, ex_mon, ex_cp, ex_ctrl, ex_noise, oe_n, 1'b0});
      host.send_word(w);
   endtask

   // One phase-detector tick, flags scrambled outside it
   task automatic tick(input logic lo, input logic hi);
      @(negedge clk);
      pfd_tick = 1'b1;
      pfd_err_below_min = lo;
      pfd_err_above_max = hi;
      @(negedge clk);
      step_rnd();
      pfd_tick = 1'b0;
      pfd_err_below_min = rnd[2];
      pfd_err_above_max = rnd[3];
      repeat (rnd[1:0]) @(negedge clk);
   endtask

   // Fields settle four edges after the strobe rise
   initial begin
      forever begin
         @(posedge latch_load_strobe);
         repeat (4) @(posedge clk);
         #1;
         if (exp_q.size() == 0) begin
            failures++;
            $display("mismatch at %0t: result with no note", $time);
         end else begin
            check(obs, exp_q.pop_front());
         end
      end
   end

   initial begin
      #400000;
      failures++;
      $display("mismatch at %0t: watchdog expired", $time);
      close_out();
   end

   initial begin
      logic [F12_W-1:0] d, n;
      logic [INT_W-1:0] wv;
      rst_n = 1'b0;
      pfd_tick = 1'b0;
      pfd_err_below_min = 1'b0;
      pfd_err_above_max = 1'b0;
      rnd = 16'h0046;
      {ex_int, ex_num, ex_den, ex_pend, ex_res, ex_qs} = '0;
      {ex_mon, ex_cp, ex_ctrl, ex_noise} = '0;
      failures = 0;
      tests_run = 0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check(obs, 104'h2);
      step_rnd();
      wr({rnd, 2'h0, rnd[5:0]} & 24'hFFFFDF | 24'h000002);
      step_rnd();
      wr({rnd, rnd[7:0]} | 24'h000003);
      // whole value kept in range, boundaries first
      for (int i = 0; i < 8; i++) begin
         step_rnd();
         d = rnd[11:0] | 12'h002;
         wr({1'b0, 3'(i), 2'h0, rnd[15:12], d, 2'h1});
         step_rnd();
         wr({1'b1, 3'(i), 2'h0, rnd[3:0], rnd[11:0], 2'h1});
         step_rnd();
         wv = (i == 0) ? INT_MIN : (i == 1) ? INT_MAX : rnd[8:0];
         if (wv < INT_MIN)
            wv = wv + INT_MIN;
         n = (i == 2) ? d : 12'(13'(rnd[11:0]) % (13'(d) + 13'h1));
         wr({1'(i), wv, n, 2'h0});
         wr({~1'(i), wv, n, 2'h0});
      end
      wr({4'h6, 6'h00, 12'h010, 2'h1});
      wr({1'b0, INT_MIN, 12'h008, 2'h0});
      repeat (6) @(negedge clk);
      repeat (23) tick(1'b1, 1'b0);
      @(negedge clk);
      check(104'(lock_detect), 104'h0);
      tick(1'b1, 1'b0);
      @(negedge clk);
      check(104'(lock_detect), 104'h1);
      @(negedge clk);
      check(104'(monitor_output_o), 104'h1);
      tick(1'b0, 1'b0);
      @(negedge clk);
      check(104'(lock_detect), 104'h1);
      tick(1'b0, 1'b1);
      @(negedge clk);
      check(104'(lock_detect), 104'h0);
      wr({ex_ctrl[23:6], 1'b1, ex_ctrl[4:0]});
      repeat (6) @(negedge clk);
      check(104'(lock_precision_select), 104'h1);
      repeat (39) tick(1'b1, 1'b0);
      @(negedge clk);
      check(104'(lock_detect), 104'h0);
      tick(1'b1, 1'b0);
      @(negedge clk);
      check(104'(lock_detect), 104'h1);
      wr({4'hD, 6'h00, 12'h010, 2'h1});
      wr({1'b0, INT_MAX, 12'h004, 2'h0});
      repeat (6) @(negedge clk);
      check(104'(lock_detect), 104'h0);
      close_out();
   end
endmodule
